//--- hdl/scmc_pkg.sv
/*
 Shared constants and types for the serial command and configuration memory block.
 Assumes a 50 MHz system clock and a host that speaks I2C or SPI as the bus master.
*/
package scmc_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROG_TIME_NS = 10000;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_CYCLES = 2;
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	// ----------------------------------------------------------------
	// Memory layout
	// ----------------------------------------------------------------
	localparam int CUST_WORDS = 24;
	localparam logic [1:0] PAGE_FIRST = 2'h0;
	localparam logic [1:0] PAGE_MAX = 2'h3;
	localparam logic [4:0] ADDR_CUSTOMER_ID_LOW = 5'h00;
	localparam logic [4:0] ADDR_CUSTOMER_ID_HIGH = 5'h01;
	localparam logic [4:0] ADDR_SERIAL_PORT_SETUP = 5'h02;
	localparam logic [4:0] ADDR_CHECKSUM = 5'h17;
	localparam logic [15:0] RST_CUSTOMER_ID_LOW = 16'h0000;
	localparam logic [15:0] RST_CUSTOMER_ID_HIGH = 16'h0000;
	localparam logic [15:0] RST_SERIAL_PORT_SETUP = 16'h0000;
	localparam logic [15:0] RST_ERASED_WORD = 16'h0000;

	// ----------------------------------------------------------------
	// Commands
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_FIRST = 8'h00;
	localparam logic [7:0] CMD_READ_LAST = 8'h17;
	localparam logic [7:0] CMD_MSTAT_FIRST = 8'h20;
	localparam logic [7:0] CMD_MSTAT_LAST = 8'h37;
	localparam logic [7:0] CMD_WRITE_FIRST = 8'h40;
	localparam logic [7:0] CMD_WRITE_LAST = 8'h57;
	localparam logic [7:0] CMD_PAGE_INC = 8'h5e;
	localparam logic [7:0] CMD_FWRITE_FIRST = 8'h60;
	localparam logic [7:0] CMD_FWRITE_LAST = 8'h7f;
	localparam logic [7:0] CMD_FSTAT_FIRST = 8'h80;
	localparam logic [7:0] CMD_FSTAT_LAST = 8'h8e;
	localparam logic [7:0] CMD_NOP = 8'hf0;

	// ----------------------------------------------------------------
	// Serial port codes and status fields
	// ----------------------------------------------------------------
	localparam logic [6:0] HS_CODE_FIRST = 7'h04;
	localparam logic [6:0] HS_CODE_LAST = 7'h07;
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;
	localparam logic [1:0] MODE_COMMAND = 2'h1;
	localparam logic NO_CORRECTION = 1'b0;
	localparam logic [11:0] MSTAT_UNDEF = 12'h000;
	localparam int RESP_W = 24;

	typedef struct packed {
		logic zero;
		logic powered;
		logic busy;
		logic [1:0] mode;
		logic mem_err;
		logic xfer;
		logic special;
	} scmc_status_t;

	typedef struct packed {
		logic corrected;
		logic [1:0] page;
		logic crc_done;
		logic [11:0] undef;
	} scmc_mstat_t;

	typedef struct packed {
		logic [3:0] unassigned;
		logic [1:0] serial_clock_mode;
		logic ss_pol;
		logic [1:0] rsvd;
		logic [6:0] target_addr;
	} scmc_cfg_t;
endpackage

//--- hdl/scmc_sync.sv
/*
 Two-stage level synchroniser for a bundle of asynchronous inputs.
 Assumes each bit is an independent level; no word coherence is implied.
*/
`timescale 1ns/1ps
`default_nettype none
module scmc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- hdl/scmc_spi_link.sv
/*
 SPI shift logic running on the host's serial clock (already edge-corrected).
 Assumes frame_idle is high between frames and resp stays still during a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module scmc_spi_link (
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic frame_idle,
	input wire logic mosi,
	input wire logic [scmc_pkg::RESP_W-1:0] resp,
	output logic [scmc_pkg::RESP_W-1:0] cmd_word_q,
	output logic cmd_tgl_q,
	output logic miso_q
);
	import scmc_pkg::*;

	logic [4:0] cnt_q;
	logic [RESP_W-1:0] sh_q;

	function automatic logic resp_bit(input logic [RESP_W-1:0] w, input logic [4:0] n);
		logic b;
		b = 1'b0;
		if (n < 5'(RESP_W))
			b = w[5'(RESP_W - 1) - n];
		return b;
	endfunction

	// ----------------------------------------------------------------
	// Receive; the clock stops between frames, so the frame signal clears
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk or posedge frame_idle) begin
		if (frame_idle) begin
			cnt_q <= 5'h00;
			sh_q <= '0;
		end else begin
			sh_q <= {sh_q[RESP_W-2:0], mosi};
			if (cnt_q < 5'(RESP_W))
				cnt_q <= cnt_q + 5'h01;
		end
	end

	// Command of exactly three bytes is handed over by a toggle
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_word_q <= '0;
			cmd_tgl_q <= 1'b0;
		end else if (!frame_idle && cnt_q == 5'(RESP_W - 1)) begin
			cmd_word_q <= {sh_q[RESP_W-2:0], mosi};
			cmd_tgl_q <= ~cmd_tgl_q;
		end
	end

	// ----------------------------------------------------------------
	// Transmit on the opposite edge; bit 23 of a response is always zero
	// ----------------------------------------------------------------
	always_ff @(negedge link_clk or posedge frame_idle) begin
		if (frame_idle)
			miso_q <= 1'b0;
		else
			miso_q <= resp_bit(resp, cnt_q);
	end
endmodule
`default_nettype wire

//--- hdl/scmc_top.sv
/*
 Serial command port (I2C target or SPI) with the paged configuration memory.
 Assumes SYS_CLK at 50 MHz, POR_N pulsed once at power-up, and SPI_SCLK from the host.
*/
`timescale 1ns/1ps
`default_nettype none
module scmc_top #(
	parameter logic FACT_CRC_DONE = 1'b1
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic POR_N,
	input wire logic SEL,
	input wire logic VPP_OK,
	input wire logic I2C_SCL,
	input wire logic I2C_SDA_I,
	output logic I2C_SDA_O,
	output logic I2C_SDA_OE,
	input wire logic SPI_SCLK,
	input wire logic SPI_SS,
	input wire logic SPI_MOSI,
	output logic SPI_MISO
);
	import scmc_pkg::*;

	typedef enum logic [6:0] {
		I_IDLE = 7'h01,
		I_ADDR = 7'h02,
		I_AACK = 7'h04,
		I_WR = 7'h08,
		I_WACK = 7'h10,
		I_RD = 7'h20,
		I_RACK = 7'h40
	} scmc_i2c_st_t;

	function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
		return (c >= lo) && (c <= hi);
	endfunction

	function automatic logic [4:0] word_index(input logic [7:0] c, input logic [7:0] base);
		logic [7:0] diff;
		diff = c - base;
		return diff[4:0];
	endfunction

	function automatic logic [15:0] reset_word(input int idx);
		logic [15:0] w;
		w = RST_ERASED_WORD;
		if (idx == int'(ADDR_CUSTOMER_ID_LOW))
			w = RST_CUSTOMER_ID_LOW;
		if (idx == int'(ADDR_CUSTOMER_ID_HIGH))
			w = RST_CUSTOMER_ID_HIGH;
		if (idx == int'(ADDR_SERIAL_PORT_SETUP))
			w = RST_SERIAL_PORT_SETUP;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync_q;
	logic spi_tgl;
	logic sel_s, vpp_s, scl_s, sda_s, ss_s, tgl_s;
	scmc_sync #(.WIDTH(6)) u_sync (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.d({spi_tgl, SPI_SS, I2C_SDA_I, I2C_SCL, VPP_OK, SEL}),
		.q(sync_q)
	);
	assign {tgl_s, ss_s, sda_s, scl_s, vpp_s, sel_s} = sync_q;

	// ----------------------------------------------------------------
	// Paged configuration memory, cleared by power-on reset and by each page increment
	// ----------------------------------------------------------------
	logic [15:0] mem_q [CUST_WORDS];
	logic [CUST_WORDS-1:0] written_q;
	logic [1:0] page_q;
	logic crc_done_q;
	scmc_cfg_t cfg;
	assign cfg = scmc_cfg_t'(mem_q[ADDR_SERIAL_PORT_SETUP]);

	logic busy_q, finish, req, spi_req, tgl_p_q, i2c_req_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0] cmd_q;
	logic [15:0] arg_q;
	logic [23:0] req_word, i2c_word_q, spi_word;
	logic is_rd, is_mst, is_fst, is_wr, is_inc, is_fwr, wr_reject, inc_reject;
	logic [4:0] widx, ridx;

	assign is_rd = in_range(cmd_q, CMD_READ_FIRST, CMD_READ_LAST);
	assign is_mst = in_range(cmd_q, CMD_MSTAT_FIRST, CMD_MSTAT_LAST);
	assign is_fst = in_range(cmd_q, CMD_FSTAT_FIRST, CMD_FSTAT_LAST);
	assign is_wr = in_range(cmd_q, CMD_WRITE_FIRST, CMD_WRITE_LAST);
	assign is_fwr = in_range(cmd_q, CMD_FWRITE_FIRST, CMD_FWRITE_LAST);
	assign is_inc = cmd_q == CMD_PAGE_INC;
	assign widx = word_index(cmd_q, CMD_WRITE_FIRST);
	assign ridx = word_index(cmd_q, CMD_READ_FIRST);
	// Programming without supply is refused rather than left half written
	assign wr_reject = written_q[widx] || !vpp_s;
	assign inc_reject = (page_q == PAGE_MAX) || !vpp_s;
	assign finish = busy_q && (cnt_q == CNT_W'(1));

	always_ff @(posedge SYS_CLK) begin
		if (!POR_N) begin
			for (int i = 0; i < CUST_WORDS; i++)
				mem_q[i] <= reset_word(i);
			written_q <= '0;
			page_q <= PAGE_FIRST;
			crc_done_q <= 1'b0;
		end else if (finish && is_wr && !wr_reject) begin
			mem_q[widx] <= arg_q;
			written_q[widx] <= 1'b1;
			if (widx == ADDR_CHECKSUM)
				crc_done_q <= 1'b1;
		end else if (finish && is_inc && !inc_reject) begin
			page_q <= page_q + 2'h1;
			written_q <= '0;
			crc_done_q <= 1'b0;
			for (int i = 0; i < CUST_WORDS; i++)
				mem_q[i] <= reset_word(i);
		end
	end

	// ----------------------------------------------------------------
	// Command interpreter
	// ----------------------------------------------------------------
	assign spi_req = (tgl_s != tgl_p_q) && (spi_word[23:16] != CMD_NOP);
	assign req = sel_s ? i2c_req_q : spi_req;
	assign req_word = sel_s ? i2c_word_q : spi_word;

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN)
			tgl_p_q <= 1'b0;
		else
			tgl_p_q <= tgl_s;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			cmd_q <= 8'h00;
			arg_q <= 16'h0000;
		end else if (busy_q) begin
			cnt_q <= cnt_q - CNT_W'(1);
			if (finish)
				busy_q <= 1'b0;
		end else if (req) begin
			busy_q <= 1'b1;
			cmd_q <= req_word[23:16];
			arg_q <= req_word[15:0];
			if (in_range(req_word[23:16], CMD_WRITE_FIRST, CMD_WRITE_LAST) || req_word[23:16] == CMD_PAGE_INC)
				cnt_q <= CNT_W'(PROG_CYCLES);
			else
				cnt_q <= CNT_W'(EXEC_CYCLES);
		end
	end

	// Result data is only meaningful once busy has dropped
	logic [15:0] resp_data_q;
	logic xfer_q;
	scmc_status_t status;
	assign status = '{zero: 1'b0, powered: 1'b1, busy: busy_q, mode: MODE_COMMAND, mem_err: 1'b0,
		xfer: xfer_q, special: 1'b0};

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			resp_data_q <= 16'h0000;
			xfer_q <= 1'b0;
		end else if (finish) begin
			xfer_q <= 1'b0;
			if (is_wr)
				xfer_q <= wr_reject;
			else if (is_inc)
				xfer_q <= inc_reject;
			else if (is_fwr)
				xfer_q <= 1'b1;
			else if (is_rd) begin
				resp_data_q <= mem_q[ridx];
				xfer_q <= NO_CORRECTION;
			end else if (is_mst)
				resp_data_q <= scmc_mstat_t'{corrected: NO_CORRECTION, page: page_q,
					crc_done: crc_done_q, undef: MSTAT_UNDEF};
			else if (is_fst)
				resp_data_q <= scmc_mstat_t'{corrected: NO_CORRECTION, page: page_q, crc_done: FACT_CRC_DONE,
					undef: MSTAT_UNDEF};
			else
				resp_data_q <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// SPI link; response is frozen while a frame is under way
	// ----------------------------------------------------------------
	logic [RESP_W-1:0] spi_resp_q;
	logic frame_idle, link_clk;
	assign frame_idle = SEL | (SPI_SS ^ cfg.ss_pol);
	assign link_clk = SPI_SCLK ^ (cfg.serial_clock_mode[1] ^ cfg.serial_clock_mode[0]);

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN)
			spi_resp_q <= '0;
		else if (sel_s || (ss_s ^ cfg.ss_pol))
			spi_resp_q <= {status, resp_data_q};
	end

	scmc_spi_link u_spi (
		.link_clk(link_clk),
		.rst_n(RSTN),
		.frame_idle(frame_idle),
		.mosi(SPI_MOSI),
		.resp(spi_resp_q),
		.cmd_word_q(spi_word),
		.cmd_tgl_q(spi_tgl),
		.miso_q(SPI_MISO)
	);

	// ----------------------------------------------------------------
	// I2C target, oversampled; SCL is never driven, so no stretching
	// ----------------------------------------------------------------
	scmc_i2c_st_t i_st_q;
	logic scl_p_q, sda_p_q, i_rw_q, i_nack_q;
	logic [7:0] i_sh_q, i_tx_q, rd_byte;
	logic [3:0] i_bit_q;
	logic [1:0] i_byte_q;
	logic start, stop, rise, fall, addr_ok;
	assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign rise = scl_s && !scl_p_q;
	assign fall = !scl_s && scl_p_q;
	assign addr_ok = (i_sh_q[7:1] == cfg.target_addr) && (i_sh_q[7:3] != TEN_BIT_HEADER)
		&& !(i_sh_q[7:1] >= HS_CODE_FIRST && i_sh_q[7:1] <= HS_CODE_LAST);

	always_comb begin
		case (i_byte_q)
			2'h0: rd_byte = status;
			2'h1: rd_byte = resp_data_q[15:8];
			2'h2: rd_byte = resp_data_q[7:0];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		i2c_req_q <= 1'b0;
		if (!RSTN || !sel_s) begin
			i_st_q <= I_IDLE;
			I2C_SDA_OE <= 1'b0;
			I2C_SDA_O <= 1'b0;
			i_sh_q <= 8'h00;
			i_tx_q <= 8'h00;
			i_bit_q <= 4'h0;
			i_byte_q <= 2'h0;
			i_rw_q <= 1'b0;
			i_nack_q <= 1'b0;
			i2c_word_q <= 24'h000000;
			i2c_req_q <= 1'b0;
		end else if (start) begin
			i_st_q <= I_ADDR;
			I2C_SDA_OE <= 1'b0;
			i_bit_q <= 4'h0;
			i_byte_q <= 2'h0;
		end else if (stop) begin
			if (i_st_q inside {I_WR, I_WACK} && i_byte_q != 2'h0)
				i2c_req_q <= 1'b1;
			i_st_q <= I_IDLE;
			I2C_SDA_OE <= 1'b0;
		end else begin
			if (rise && i_st_q inside {I_ADDR, I_WR}) begin
				i_sh_q <= {i_sh_q[6:0], sda_s};
				i_bit_q <= i_bit_q + 4'h1;
			end
			case (i_st_q)
				I_ADDR: if (fall && i_bit_q == 4'h8) begin
					i_rw_q <= i_sh_q[0];
					i_st_q <= addr_ok ? I_AACK : I_IDLE;
					I2C_SDA_OE <= addr_ok;
				end
				I_AACK: if (fall) begin
					i_bit_q <= 4'h0;
					i_st_q <= i_rw_q ? I_RD : I_WR;
					i_tx_q <= rd_byte;
					I2C_SDA_OE <= i_rw_q && !rd_byte[7];
				end
				I_WR: if (fall && i_bit_q == 4'h8) begin
					if (i_byte_q == 2'h0)
						i2c_word_q <= {i_sh_q, 16'h0000};
					else if (i_byte_q == 2'h1)
						i2c_word_q[15:8] <= i_sh_q;
					else
						i2c_word_q[7:0] <= i_sh_q;
					i_byte_q <= i_byte_q + 2'h1;
					i_st_q <= I_WACK;
					I2C_SDA_OE <= 1'b1;
				end
				I_WACK: if (fall) begin
					I2C_SDA_OE <= 1'b0;
					i_bit_q <= 4'h0;
					i_st_q <= I_WR;
					if (i_byte_q == 2'h3) begin
						i2c_req_q <= 1'b1;
						i_byte_q <= 2'h0;
					end
				end
				I_RD: begin
					if (rise)
						i_bit_q <= i_bit_q + 4'h1;
					if (fall && i_bit_q == 4'h8) begin
						i_st_q <= I_RACK;
						I2C_SDA_OE <= 1'b0;
						if (i_byte_q != 2'h3)
							i_byte_q <= i_byte_q + 2'h1;
					end else if (fall) begin
						i_tx_q <= {i_tx_q[6:0], 1'b0};
						I2C_SDA_OE <= !i_tx_q[6];
					end
				end
				I_RACK: begin
					if (rise)
						i_nack_q <= sda_s;
					if (fall) begin
						i_bit_q <= 4'h0;
						i_st_q <= i_nack_q ? I_IDLE : I_RD;
						i_tx_q <= rd_byte;
						I2C_SDA_OE <= !i_nack_q && !rd_byte[7];
					end
				end
				I_IDLE: i_bit_q <= 4'h0;
				default: i_st_q <= I_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	page_step_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
		(page_q != $past(page_q)) |-> (page_q == $past(page_q) + 2'h1 && $past(page_q) != PAGE_MAX))
		else $error("page counter moved other than by one step");
	last_page_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
		(finish && is_inc && page_q == PAGE_MAX) |=> (xfer_q && page_q == PAGE_MAX))
		else $error("increment on last page not refused");
	write_once_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
		(finish && is_wr && written_q[widx]) |=> (xfer_q && mem_q[$past(widx)] == $past(mem_q[widx])))
		else $error("second write to a word was not refused");
	factory_lock_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
		(finish && is_fwr) |=> (xfer_q && $stable(written_q)))
		else $error("factory write not refused");
	busy_ignore_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(busy_q && !finish && req) |=> (busy_q && cmd_q == $past(cmd_q)))
		else $error("command taken while busy");
	accept_busy_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(!busy_q && req) |=> (busy_q ##1 busy_q))
		else $error("accepted command did not show busy");
	mstat_page_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
		(finish && is_mst) |=> (resp_data_q[14:13] == page_q && resp_data_q[15] == NO_CORRECTION))
		else $error("memory status page field wrong");
	hs_nack_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(i_st_q == I_ADDR && fall && i_bit_q == 4'h8 && i_sh_q[7:1] >= HS_CODE_FIRST
		&& i_sh_q[7:1] <= HS_CODE_LAST) |=> !I2C_SDA_OE)
		else $error("reserved address acknowledged");
	spi_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(!sel_s && !$past(sel_s)) |-> !I2C_SDA_OE)
		else $error("SDA driven in SPI mode");
	status_live_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(i_st_q == I_AACK && fall && i_rw_q && !start && !stop) |=> (i_tx_q[5] == $past(busy_q)))
		else $error("status byte does not show busy");
endmodule
`default_nettype wire

//--- bench/scmc_host.sv
/*
 Host model: SPI master that frames 24-bit commands for the serial command block.
 Assumes the block latches on the first clock edge of a bit (modes 00 and 10 only).
*/
`timescale 1ns/1ps
`default_nettype none
module scmc_host (
	output logic sclk,
	output logic ss,
	output logic mosi,
	input wire logic miso
);
	logic ss_pol;
	initial begin
		ss_pol = 1'b0;
		ss = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Clock idles at the mode's level and stands still between frames
	task automatic cfg(input logic pol, input logic [1:0] ckm);
		ss_pol = pol;
		ss = ~pol;
		sclk = ckm[1];
	endtask
	// Always three whole bytes per frame
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		#7 ss = ss_pol;
		for (int i = 23; i >= 0; i--) begin
			mosi = tx[i];
			#32 sclk = ~sclk;
			rx[i] = miso;
			#32 sclk = ~sclk;
		end
		#32 ss = ~ss_pol;
		// Released line flips so a stale level never passes for data
		mosi = ~mosi;
	endtask
endmodule
`default_nettype wire

//--- bench/tb_scmc_top.sv
/*
 Self-checking bench for scmc_top over SPI, against a behavioural memory model.
 Assumes scmc_host as the far side and the scmc_pkg constants.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_scmc_top;
	import scmc_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn, por_n, vpp_ok, sclk, ss, mosi, miso, sda_o, sda_oe, crc, eb1;
	logic [31:0] rs = 32'h21;
	logic [15:0] mem [24];
	logic [23:0] wr, rx;
	logic [1:0] page;
	logic [15:0] ed, em, v;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// ----------------------------------------------------------------
	// Clock, partner, design
	// ----------------------------------------------------------------
	always #10 sys_clk = ~sys_clk;
	scmc_host host (.sclk(sclk), .ss(ss), .mosi(mosi), .miso(miso));
	scmc_top uut (.SYS_CLK(sys_clk), .RSTN(rstn), .POR_N(por_n), .SEL(1'b0), .VPP_OK(vpp_ok),
		.I2C_SCL(1'b1), .I2C_SDA_I(1'b1), .I2C_SDA_O(sda_o), .I2C_SDA_OE(sda_oe),
		.SPI_SCLK(sclk), .SPI_SS(ss), .SPI_MOSI(mosi), .SPI_MISO(miso));
	// About 25 commands of under 900 cycles each; generous ceiling
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors = num_errors + 1;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// Helpers and model
	// ----------------------------------------------------------------
	function automatic logic [15:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[15:0];
	endfunction
	task automatic chk_stat(input logic [6:0] got, input logic [6:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: status %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
		checks_done++;
		if ((got & m) !== (exp & m)) begin
			num_errors++;
			$display("wrong value at %0t: data %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic mdl(input logic [7:0] c, input logic [15:0] d);
		eb1 = 1'b0;
		em = 16'h0;
		ed = 16'h0;
		if (c <= CMD_READ_LAST) begin
			ed = mem[c[4:0]];
			em = 16'hffff;
		end else if (c inside {[8'h20:8'h37], [8'h80:8'h8e]}) begin
			ed = {1'b0, page, c[7] | crc, 12'h0};
			em = 16'hf000;
		end else if (c inside {[8'h40:8'h57]}) begin
			if (wr[c[4:0]] || !vpp_ok) eb1 = 1'b1;
			else begin
				mem[c[4:0]] = d;
				wr[c[4:0]] = 1'b1;
				crc |= (c == 8'h57);
			end
		end else if (c == 8'h5e) begin
			if (page == 2'h3 || !vpp_ok) eb1 = 1'b1;
			else begin
				page++;
				wr = '0;
				crc = 1'b0;
				foreach (mem[i]) mem[i] = 16'h0;
			end
		end else eb1 = 1'b1;
	endtask
	task automatic do_cmd(input logic [7:0] c, input logic [15:0] d, input logic jam);
		logic [23:0] r;
		int n;
		host.xfer({c, d}, r);
		mdl(c, d);
		n = 0;
		do begin
			repeat (8) @(negedge sys_clk);
			host.xfer(24'hf00000, r);
			if (n == 0 && c[7:6] == 2'h1 && !eb1) begin
				chk_stat({6'h0, r[21]}, 7'h1);
				if (jam) host.xfer({8'h41, rnd()}, r);
			end
			n++;
		end while (r[21] !== 1'b0 && n < 20);
		chk_stat(r[23:17], {3'h2, MODE_COMMAND, 1'b0, eb1});
		chk_data(r[15:0], ed, em);
		chk_data({14'h0, sda_o, sda_oe}, 16'h0, 16'h3);
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		por_n = 1'b0;
		vpp_ok = 1'b1;
		wr = '0;
		page = 2'h0;
		crc = 1'b0;
		foreach (mem[i]) mem[i] = 16'h0;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		por_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		for (int a = 0; a < 3; a++) do_cmd(8'(a), 16'h0, 1'b0);
		do_cmd(8'h20, 16'h0, 1'b0);
		do_cmd(8'h80, 16'h0, 1'b0);
		$display("test reset contents finished");
		v = rnd();
		do_cmd(8'h40, v, 1'b1);
		do_cmd(8'h01, 16'h0, 1'b0);
		do_cmd(8'h40, ~v, 1'b0);
		do_cmd(8'h00, 16'h0, 1'b0);
		@(negedge sys_clk);
		vpp_ok = 1'b0;
		do_cmd(8'h42, rnd(), 1'b0);
		@(negedge sys_clk);
		vpp_ok = 1'b1;
		do_cmd(8'h60, rnd(), 1'b0);
		do_cmd(8'h7f, rnd(), 1'b0);
		do_cmd(8'h57, rnd(), 1'b0);
		do_cmd(8'h37, 16'h0, 1'b0);
		$display("test writes finished");
		for (int p = 0; p < 4; p++) begin
			do_cmd(8'h5e, 16'h0, 1'b0);
			do_cmd(8'h20, 16'h0, 1'b0);
			do_cmd(8'h00, 16'h0, 1'b0);
		end
		$display("test pages finished");
		v = rnd();
		v = {4'h0, 2'h2, 1'b1, 2'h0, v[6:0]};
		host.xfer({8'h42, v}, rx);
		mdl(8'h42, v);
		// Polling is skipped: select polarity flips when the word lands
		repeat (PROG_CYCLES + 100) @(negedge sys_clk);
		host.cfg(1'b1, 2'h2);
		do_cmd(8'h02, 16'h0, 1'b0);
		$display("test serial setup finished");
		final_report();
	end
endmodule
`default_nettype wire
